// *** sfs_supervisor.sv ***
// Stepper fault supervisor: flags, fault output, bridge gating, power state.
// Assumes the SPI decoder turns reads and writes into one-cycle strobes.
//
// Contract
// - Coil current level change applies at next PWM period start.
// - Bridge enable low still lets triggers move the positioner.
// - Sleep ignores step and rotation-sense pins entirely.
// - Bridge supply undervoltage latches its flag and pulls fault low.
// - Enable write of 1 is refused while undervoltage flag set.
// - Open coil: full duty held past the selected timeout.
// - Only conducting coils checked; full steps check one coil.
// - Open coil latches coil open flag and electrical fault flag.
// - Open coil reaction chosen by keep-driving and disable-both bits.
// - Overcurrent latches its bit, electrical fault, drops bridge enable.
// - Electrical fault is OR of latched flags, cleared by reading them.
// - Trigger or position write during a fault sets step lost.
// - Step lost stays until its status register is read.
// - Thermal warning sets flag, pulls fault low, keeps motor on.
// - Thermal shutdown sets flag, drops enable, blocks pattern reset.
// - Shutdown flag clears only after cooling and a host read.
// - Enable write of 1 needs both thermal flags clear.
// - Thermal warning drops boosted current to the unboosted level.
// - Fault output low on any error or reset state, high asleep.
// - Sleep after reset or request: drivers off, registers kept.
// - Chip-select low pulse wakes; request bit clears; recovery wait.
// - Five rotation-sense patterns with step high reset the logic.
// - Step trigger: step pin rise or soft step bit, self-clearing.
`timescale 1ns/10ps
`include "sfs_defines.svh"
module sfs_supervisor
  import sfs_pkg::*;
#(
  parameter int unsigned HR_ERR_CYC = `SFS_T_HR_ERR_US * `SFS_CLK_MHZ,
  parameter int unsigned WU_CYC     = `SFS_T_WU_US * `SFS_CLK_MHZ
)(
  // Clock and power-on reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // Pins from the host
  input  wire logic       step_pulse_pin_i,
  input  wire logic       rotation_sense_pin_i,
  input  wire logic       chip_select_n_i,
  // Control bits and write strobes
  input  wire logic [3:0] coil_current_level_i,
  input  wire logic       current_boost_bit_i,
  input  wire logic       bridge_enable_wr_i,
  input  wire logic       bridge_enable_wdata_i,
  input  wire logic       soft_step_set_i,
  input  wire logic       sleep_request_set_i,
  input  wire logic       microstep_wr_i,
  input  wire logic [5:0] microstep_wdata_i,
  input  wire logic [1:0] open_load_timeout_i,
  input  wire logic       open_load_keep_driving_i,
  input  wire logic       open_load_disable_both_i,
  // Status read strobes
  input  wire logic       rd_elec_status_i,
  input  wire logic       rd_main_status_i,
  // Analog monitors and PWM
  input  wire logic       uv_detect_i,
  input  wire logic       tw_detect_i,
  input  wire logic       tsd_detect_i,
  input  wire logic [7:0] overcurrent_detect_i,
  input  wire logic [1:0] duty_full_i,
  input  wire logic       pwm_period_start_i,
  input  wire logic       spi_error_flag_i,
  // Bridge and current outputs
  output logic            bridge_enable_o,
  output logic            bridge_a_drive_o,
  output logic            bridge_b_drive_o,
  output logic [3:0]      coil_current_applied_o,
  output logic            boost_applied_o,
  output logic [5:0]      microstep_position_o,
  // Status flags
  output logic            undervoltage_flag_o,
  output logic            thermal_warning_flag_o,
  output logic            thermal_shutdown_flag_o,
  output logic [7:0]      overcurrent_flags_o,
  output logic            coil_a_open_flag_o,
  output logic            coil_b_open_flag_o,
  output logic            electrical_fault_flag_o,
  output logic            step_lost_flag_o,
  output logic            reset_occurred_flag_o,
  output logic            soft_step_bit_o,
  output logic            sleep_request_bit_o,
  output logic            awake_o,
  // Open-drain fault pin
  output logic            fault_out_n_o,
  output logic            fault_oe_n_o
);

  sfs_pin_if  pin ();
  sfs_state_t state;
  logic       core_rst_n;
  logic       run;
  logic       step_trig;
  logic       fault_any;
  logic       tsd_read;
  logic       coil_a_off;
  logic       coil_b_off;
  logic [1:0] open_hit;
  logic [1:0] chk;
  logic [7:0] oc_hit;
  logic [31:0] timer;
  logic [8:0] csn_low;

  // Coil conducts unless the position is a full step of the other coil
  function automatic logic coil_checked(input logic [5:0] pos,
                                        input logic       coil_b);
    logic a_only;
    logic b_only;
    a_only = (pos == `SFS_POS_FS0) || (pos == `SFS_POS_FS2);
    b_only = (pos == `SFS_POS_FS1) || (pos == `SFS_POS_FS3);
    return coil_b ? !a_only : !b_only;
  endfunction

  // Open-load timeout in PWM periods per field code
  function automatic logic [8:0] ol_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    ol_limit = `SFS_OL_PER0;
      2'h1:    ol_limit = `SFS_OL_PER1;
      2'h2:    ol_limit = `SFS_OL_PER2;
      default: ol_limit = `SFS_OL_PER3;
    endcase
  endfunction

  sfs_pin_sync u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .pins_i    ({chip_select_n_i, rotation_sense_pin_i, step_pulse_pin_i}),
    .pin       (pin)
  );

  // Pattern reset drops the whole core like power-on
  assign core_rst_n   = rst_n_i && !pin.hr_fire;
  assign run          = (state == SFS_ST_RUN);
  assign pin.hr_allow = run && !thermal_shutdown_flag_o;
  assign step_trig    = run && (pin.step_rise || soft_step_bit_o);
  assign fault_any    = undervoltage_flag_o || thermal_shutdown_flag_o ||
                        electrical_fault_flag_o;
  assign chk[0]       = coil_checked(microstep_position_o, 1'b0);
  assign chk[1]       = coil_checked(microstep_position_o, 1'b1);
  assign oc_hit       = run ? (overcurrent_detect_i &
                        {{4{chk[1]}}, {4{chk[0]}}}) : 8'h00;
  assign awake_o      = run;

  // Power state: reset hold, sleep, wake recovery, run
  always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      state   <= SFS_ST_RESET;
      timer   <= 32'h0000_0000;
      csn_low <= 9'h000;
    end else begin
      case (state)
        SFS_ST_RESET: begin
          timer <= timer + 32'h0000_0001;
          if (timer >= HR_ERR_CYC - 1) begin
            state <= SFS_ST_SLEEP;
            timer <= 32'h0000_0000;
          end
        end
        SFS_ST_SLEEP: begin
          if (!pin.csn_lvl && csn_low != 9'h1FF) begin
            csn_low <= csn_low + 9'h001;
          end else if (pin.csn_lvl) begin
            csn_low <= 9'h000;
          end
          if (pin.csn_rise && csn_low >= 9'(`SFS_CSB_MIN_CYC)) begin
            state <= SFS_ST_WAKE;
          end
        end
        SFS_ST_WAKE: begin
          timer <= timer + 32'h0000_0001;
          if (timer >= WU_CYC - 1) begin
            state <= SFS_ST_RUN;
            timer <= 32'h0000_0000;
          end
        end
        SFS_ST_RUN: begin
          if (sleep_request_bit_o) begin
            state <= SFS_ST_SLEEP;
          end
        end
        default: state <= SFS_ST_RESET;
      endcase
    end
  end

  // Sleep request bit: set by reset or host, cleared on wake
  always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      sleep_request_bit_o <= 1'b1;
    end else if (sleep_request_set_i) begin
      sleep_request_bit_o <= 1'b1;
    end else if (state == SFS_ST_SLEEP && state != SFS_ST_RUN &&
                 pin.csn_rise && csn_low >= 9'(`SFS_CSB_MIN_CYC)) begin
      sleep_request_bit_o <= 1'b0;
    end
  end

  // Positioner and soft step bit
  always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      microstep_position_o <= `SFS_POS_RST;
      soft_step_bit_o      <= 1'b0;
    end else begin
      if (soft_step_set_i) begin
        soft_step_bit_o <= 1'b1;
      end else if (run) begin
        soft_step_bit_o <= 1'b0;
      end
      if (microstep_wr_i) begin
        microstep_position_o <= microstep_wdata_i;
      end else if (step_trig) begin
        microstep_position_o <= pin.dir_lvl ?
          microstep_position_o + 6'h01 : microstep_position_o - 6'h01;
      end
    end
  end

  // Open-load timers, one per coil, counted in PWM periods
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_open
      logic [8:0] ol_cnt;
      logic       off;
      assign off = c ? coil_b_off : coil_a_off;
      always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
        if (!core_rst_n) begin
          ol_cnt <= 9'h000;
        end else if (!(run && bridge_enable_o && chk[c] && !off &&
                       duty_full_i[c])) begin
          ol_cnt <= 9'h000;
        end else if (pwm_period_start_i && !open_hit[c]) begin
          ol_cnt <= ol_cnt + 9'h001;
        end
      end
      assign open_hit[c] = (ol_cnt >= ol_limit(open_load_timeout_i));
    end
  endgenerate

  // Electrical fault flags: set wins over the read that clears them
  always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      overcurrent_flags_o <= 8'h00;
      coil_a_open_flag_o  <= 1'b0;
      coil_b_open_flag_o  <= 1'b0;
    end else begin
      overcurrent_flags_o <= (rd_elec_status_i ? 8'h00 :
                              overcurrent_flags_o) | oc_hit;
      coil_a_open_flag_o  <= (coil_a_open_flag_o && !rd_elec_status_i) ||
                             open_hit[0];
      coil_b_open_flag_o  <= (coil_b_open_flag_o && !rd_elec_status_i) ||
                             open_hit[1];
    end
  end

  // Combined electrical fault flag
  assign electrical_fault_flag_o = (|overcurrent_flags_o) ||
                                   coil_a_open_flag_o ||
                                   coil_b_open_flag_o;

  // Supply and thermal flags; shutdown frozen outside run
  always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      undervoltage_flag_o     <= 1'b0;
      thermal_warning_flag_o  <= 1'b0;
      thermal_shutdown_flag_o <= 1'b0;
      tsd_read                <= 1'b0;
    end else begin
      undervoltage_flag_o    <= (undervoltage_flag_o && !rd_main_status_i) ||
                                (run && uv_detect_i);
      thermal_warning_flag_o <= (thermal_warning_flag_o &&
                                 !(rd_main_status_i && !tw_detect_i)) ||
                                (run && tw_detect_i);
      if (run && tsd_detect_i) begin
        thermal_shutdown_flag_o <= 1'b1;
        tsd_read                <= 1'b0;
      end else if (run && thermal_shutdown_flag_o) begin
        if (tsd_read && !tw_detect_i) begin
          thermal_shutdown_flag_o <= 1'b0;
          tsd_read                <= 1'b0;
        end else if (rd_main_status_i) begin
          tsd_read <= 1'b1;
        end
      end
    end
  end

  // Step lost and reset occurred flags
  always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      step_lost_flag_o      <= 1'b0;
      reset_occurred_flag_o <= 1'b1;
    end else begin
      step_lost_flag_o <= (step_lost_flag_o && !rd_main_status_i) ||
                          (fault_any && (step_trig || microstep_wr_i));
      reset_occurred_flag_o <= reset_occurred_flag_o && !rd_main_status_i;
    end
  end

  // Bridge enable and single-bridge shutoff after open coil
  always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      bridge_enable_o <= 1'b0;
      coil_a_off      <= 1'b0;
      coil_b_off      <= 1'b0;
    end else begin
      if ((|oc_hit) || (run && (tsd_detect_i || uv_detect_i))) begin
        bridge_enable_o <= 1'b0;
      end else if ((|open_hit) && !open_load_keep_driving_i &&
                   open_load_disable_both_i) begin
        bridge_enable_o <= 1'b0;
      end else if (bridge_enable_wr_i) begin
        bridge_enable_o <= bridge_enable_wdata_i && !undervoltage_flag_o &&
                           !thermal_shutdown_flag_o &&
                           !thermal_warning_flag_o;
      end
      if (bridge_enable_wr_i && bridge_enable_wdata_i) begin
        coil_a_off <= 1'b0;
        coil_b_off <= 1'b0;
      end else if (!open_load_keep_driving_i && !open_load_disable_both_i) begin
        coil_a_off <= coil_a_off || open_hit[0];
        coil_b_off <= coil_b_off || open_hit[1];
      end
    end
  end

  // Bridge drives: only awake, enabled and not switched off
  always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      bridge_a_drive_o <= 1'b0;
      bridge_b_drive_o <= 1'b0;
    end else begin
      bridge_a_drive_o <= run && bridge_enable_o && !coil_a_off;
      bridge_b_drive_o <= run && bridge_enable_o && !coil_b_off;
    end
  end

  // Coil current targets latched at the PWM period boundary
  always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      coil_current_applied_o <= `SFS_LEVEL_RST;
      boost_applied_o        <= 1'b0;
    end else if (pwm_period_start_i) begin
      coil_current_applied_o <= coil_current_level_i;
      boost_applied_o <= current_boost_bit_i &&
                         !thermal_warning_flag_o && !tw_detect_i;
    end else if (thermal_warning_flag_o) begin
      boost_applied_o <= 1'b0;
    end
  end

  // Open-drain fault pin, low on error or reset state, high asleep
  always_ff @(posedge sys_clk_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      fault_out_n_o <= 1'b0;
      fault_oe_n_o  <= 1'b0;
    end else begin
      fault_out_n_o <= !((state == SFS_ST_RESET) || (state != SFS_ST_SLEEP &&
                       (spi_error_flag_i || electrical_fault_flag_o ||
                        thermal_shutdown_flag_o || thermal_warning_flag_o ||
                        undervoltage_flag_o)));
      fault_oe_n_o  <= !((state == SFS_ST_RESET) || (state != SFS_ST_SLEEP &&
                       (spi_error_flag_i || electrical_fault_flag_o ||
                        thermal_shutdown_flag_o || thermal_warning_flag_o ||
                        undervoltage_flag_o)));
    end
  end

  // Checks
  a_current_apply: assert property (
    @(posedge sys_clk_i) disable iff (!core_rst_n)
    pwm_period_start_i |=> coil_current_applied_o == $past(coil_current_level_i))
    else $error("current level not applied at period start");

  a_sleep_no_move: assert property (
    @(posedge sys_clk_i) disable iff (!core_rst_n)
    (state == SFS_ST_SLEEP && !microstep_wr_i) |=> $stable(microstep_position_o))
    else $error("positioner moved in sleep");

  a_uv_latch: assert property (
    @(posedge sys_clk_i) disable iff (!core_rst_n)
    (run && uv_detect_i && !sleep_request_bit_o) |=>
      undervoltage_flag_o ##1 !fault_out_n_o)
    else $error("undervoltage not latched");

  a_uv_enable_block: assert property (
    @(posedge sys_clk_i) disable iff (!core_rst_n)
    (bridge_enable_wr_i && undervoltage_flag_o) |=> !bridge_enable_o)
    else $error("enable accepted during undervoltage");

  a_thermal_enable: assert property (
    @(posedge sys_clk_i) disable iff (!core_rst_n)
    (bridge_enable_wr_i && thermal_warning_flag_o) |=> !bridge_enable_o)
    else $error("enable accepted during thermal warning");

  a_oc_shutdown: assert property (
    @(posedge sys_clk_i) disable iff (!core_rst_n)
    (|oc_hit) |=> (!bridge_enable_o && electrical_fault_flag_o)
                  ##1 (!bridge_a_drive_o && !bridge_b_drive_o))
    else $error("overcurrent did not shut the bridges");

  a_step_lost_set: assert property (
    @(posedge sys_clk_i) disable iff (!core_rst_n)
    (fault_any && step_trig) |=> step_lost_flag_o)
    else $error("step lost not flagged");

  a_tsd_hold: assert property (
    @(posedge sys_clk_i) disable iff (!core_rst_n)
    (thermal_shutdown_flag_o && !tsd_read) |=> thermal_shutdown_flag_o)
    else $error("shutdown flag cleared before host read");

  a_boost_drop: assert property (
    @(posedge sys_clk_i) disable iff (!core_rst_n)
    thermal_warning_flag_o |=> !boost_applied_o)
    else $error("boost kept during thermal warning");

  a_sleep_fault_high: assert property (
    @(posedge sys_clk_i) disable iff (!core_rst_n)
    (state == SFS_ST_SLEEP) [*2] |-> fault_out_n_o)
    else $error("fault pin low in sleep");

  a_sleep_no_drive: assert property (
    @(posedge sys_clk_i) disable iff (!core_rst_n)
    !run |=> (!bridge_a_drive_o && !bridge_b_drive_o))
    else $error("bridge driven while not awake");

endmodule

// *** sfs_defines.svh ***
// Constants of the stepper fault supervisor: counts, limits, reset values.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef SFS_DEFINES_SVH
`define SFS_DEFINES_SVH

// Core clock rate in MHz and in ns per cycle
`define SFS_CLK_MHZ        250
`define SFS_CLK_NS         4

// Reset-state hold of the fault output, in microseconds
`define SFS_T_HR_ERR_US    100
// Recovery time after wake-up, in microseconds
`define SFS_T_WU_US        100
// Least chip-select low pulse that wakes the chip, in nanoseconds
`define SFS_T_CSB_MIN_NS   1000
// Least time rounds up to whole cycles
`define SFS_CSB_MIN_CYC    ((`SFS_T_CSB_MIN_NS + `SFS_CLK_NS - 1) / `SFS_CLK_NS)

// Rotation-sense rising edges that make five low-high-low-high patterns
`define SFS_HR_EDGES       4'h000A

// Open-load timeouts in PWM periods, one per timeout field code
`define SFS_OL_PER0        9'h008
`define SFS_OL_PER1        9'h020
`define SFS_OL_PER2        9'h040
`define SFS_OL_PER3        9'h100

// Full-step positions where a single coil conducts
`define SFS_POS_FS0        6'h00
`define SFS_POS_FS1        6'h10
`define SFS_POS_FS2        6'h20
`define SFS_POS_FS3        6'h30

// Reset values
`define SFS_POS_RST        6'h08
`define SFS_LEVEL_RST      4'h0

`endif

// *** sfs_pkg.sv ***
// Types shared by the stepper fault supervisor modules.
// Assumes sfs_defines.svh supplies every numeric constant.
package sfs_pkg;

  // Power-state machine, one-hot
  typedef enum logic [3:0] {
    SFS_ST_RESET = 4'b0001,
    SFS_ST_SLEEP = 4'b0010,
    SFS_ST_WAKE  = 4'b0100,
    SFS_ST_RUN   = 4'b1000
  } sfs_state_t;

endpackage

// *** sfs_pin_if.sv ***
// Carrier between the pin conditioner and the supervisor core.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps
interface sfs_pin_if;
  logic step_lvl;   // Synchronised step pin
  logic dir_lvl;    // Synchronised rotation-sense pin
  logic csn_lvl;    // Synchronised chip select, active low
  logic step_rise;  // Rising edge on step pin
  logic csn_rise;   // Rising edge on chip select
  logic hr_allow;   // Pattern reset permitted
  logic hr_fire;    // Pattern reset detected, one cycle

  modport cond (output step_lvl, dir_lvl, csn_lvl, step_rise, csn_rise,
                output hr_fire, input hr_allow);
  modport core (input step_lvl, dir_lvl, csn_lvl, step_rise, csn_rise,
                input hr_fire, output hr_allow);
endinterface

// *** sfs_pin_sync.sv ***
// Pin conditioner: synchronisers, edge detection, pattern reset counter.
// Assumes pins are asynchronous to sys_clk_i; reset only by power-on.
`timescale 1ns/10ps
`include "sfs_defines.svh"
module sfs_pin_sync
  import sfs_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  // Raw pins: step, rotation sense, chip select
  input  wire logic [2:0] pins_i,
  // Conditioned pins toward the core
  sfs_pin_if.cond         pin
);

  logic [2:0] meta;
  logic [2:0] sync;
  logic [2:0] prev;
  logic [3:0] hr_cnt;
  logic       hr_fire;

  // Two-flop synchronisers and an edge stage per pin
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          // Chip select idles high: reset its stages high, no false edge
          meta[g] <= (g == 2);
          sync[g] <= (g == 2);
          prev[g] <= (g == 2);
        end else begin
          meta[g] <= pins_i[g];
          sync[g] <= meta[g];
          prev[g] <= sync[g];
        end
      end
    end
  endgenerate

  // Count rotation-sense rises while step is held high
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hr_cnt  <= 4'h0;
      hr_fire <= 1'b0;
    end else begin
      hr_fire <= 1'b0;
      if (!sync[0] || !pin.hr_allow || hr_fire) begin
        hr_cnt <= 4'h0;
      end else if (sync[1] && !prev[1]) begin
        if (hr_cnt == `SFS_HR_EDGES - 4'h1) begin
          hr_fire <= 1'b1;
          hr_cnt  <= 4'h0;
        end else begin
          hr_cnt <= hr_cnt + 4'h1;
        end
      end
    end
  end

  // Levels and edges toward the core
  assign pin.step_lvl  = sync[0];
  assign pin.dir_lvl   = sync[1];
  assign pin.csn_lvl   = sync[2];
  assign pin.step_rise = sync[0] && !prev[0];
  assign pin.csn_rise  = sync[2] && !prev[2];
  assign pin.hr_fire   = hr_fire;

endmodule

// *** sfs_host_model.sv ***
// Host model: drives the step, rotation-sense and chip-select pins.
// Assumes its tasks are called from a falling clock edge.
`timescale 1ns/10ps
module sfs_host_model (
  // Clock
  input  wire logic sys_clk_i,
  // Pins toward the device
  output logic      step_pulse_pin_o,
  output logic      rotation_sense_pin_o,
  output logic      chip_select_n_o
);
  // Idle pins: step low, chip deselected
  initial begin
    step_pulse_pin_o     = 1'b0;
    rotation_sense_pin_o = 1'b1;
    chip_select_n_o      = 1'b1;
  end
  // One step, direction settled first so the pins never overlap
  task automatic step_once(input logic up);
    rotation_sense_pin_o = up;
    repeat (4) @(negedge sys_clk_i);
    step_pulse_pin_o = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    step_pulse_pin_o = 1'b0;
    repeat (8) @(negedge sys_clk_i);
  endtask
  // Wake pulse held longer than the least width
  task automatic wake;
    chip_select_n_o = 1'b0;
    repeat (260) @(negedge sys_clk_i);
    chip_select_n_o = 1'b1;
  endtask
  // Pattern reset: ten rotation-sense rises while step is held high
  task automatic pattern_reset;
    step_pulse_pin_o = 1'b1;
    repeat (10) begin
      rotation_sense_pin_o = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      rotation_sense_pin_o = 1'b1;
      repeat (4) @(negedge sys_clk_i);
    end
    step_pulse_pin_o = 1'b0;
    repeat (4) @(negedge sys_clk_i);
  endtask
endmodule

// *** tb_stepper_fault_supervisor.sv ***
// Bench of the stepper fault supervisor: pin steps, faults, power state.
// Assumes sfs_host_model drives the pins; short reset and wake counts.
`timescale 1ns/10ps
module tb_stepper_fault_supervisor;
  logic sys_clk_i, rst_n_i, step_pulse_pin_i, rotation_sense_pin_i;
  logic chip_select_n_i, current_boost_bit_i, bridge_enable_wr_i;
  logic bridge_enable_wdata_i, soft_step_set_i, sleep_request_set_i;
  logic microstep_wr_i, open_load_keep_driving_i, open_load_disable_both_i;
  logic rd_elec_status_i, rd_main_status_i, uv_detect_i, tw_detect_i;
  logic tsd_detect_i, pwm_period_start_i, spi_error_flag_i;
  logic [3:0] coil_current_level_i, coil_current_applied_o;
  logic [5:0] microstep_wdata_i, microstep_position_o;
  logic [1:0] open_load_timeout_i, duty_full_i;
  logic [7:0] overcurrent_detect_i, overcurrent_flags_o;
  logic bridge_enable_o, bridge_a_drive_o, bridge_b_drive_o, boost_applied_o;
  logic undervoltage_flag_o, thermal_warning_flag_o, thermal_shutdown_flag_o;
  logic coil_a_open_flag_o, coil_b_open_flag_o, electrical_fault_flag_o;
  logic step_lost_flag_o, reset_occurred_flag_o, soft_step_bit_o;
  logic sleep_request_bit_o, awake_o, fault_out_n_o, fault_oe_n_o;
  int errors = 0, compares = 0, cycles = 0;
  sfs_supervisor #(.HR_ERR_CYC(8), .WU_CYC(8)) dut (.*);
  sfs_host_model host (.sys_clk_i(sys_clk_i),
    .step_pulse_pin_o(step_pulse_pin_i),
    .rotation_sense_pin_o(rotation_sense_pin_i),
    .chip_select_n_o(chip_select_n_i));
  // Clock, 4 ns period
  initial sys_clk_i = 1'b0;
  always #2 sys_clk_i = ~sys_clk_i;
  // Hang guard
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      conclude();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic chk(input logic [7:0] seen, exp, input string what);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  task automatic en_write;
    bridge_enable_wr_i = 1'b1;
    bridge_enable_wdata_i = 1'b1;
    tick(1);
    bridge_enable_wr_i = 1'b0;
    tick(2);
  endtask
  task automatic conclude;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst_n_i, coil_current_level_i, current_boost_bit_i} = '0;
    {bridge_enable_wr_i, bridge_enable_wdata_i, soft_step_set_i} = '0;
    {sleep_request_set_i, microstep_wr_i, microstep_wdata_i} = '0;
    {open_load_timeout_i, open_load_keep_driving_i} = '0;
    {open_load_disable_both_i, rd_elec_status_i, rd_main_status_i} = '0;
    {uv_detect_i, tw_detect_i, tsd_detect_i, overcurrent_detect_i} = '0;
    {duty_full_i, pwm_period_start_i, spi_error_flag_i} = '0;
    tick(10);
    rst_n_i = 1'b1;
    tick(1);
    chk(fault_out_n_o, 0, "fault high in reset state");
    chk(reset_occurred_flag_o, 1, "reset flag clear");
    tick(20);
    chk(fault_out_n_o, 1, "fault low in sleep");
    host.step_once(1'b1);
    chk(microstep_position_o, 8'h08, "moved in sleep");
    host.wake();
    tick(20);
    chk(sleep_request_bit_o, 0, "sleep bit kept");
    chk(awake_o, 1, "not awake");
    en_write();
    chk(bridge_enable_o, 1, "enable refused");
    host.step_once(1'b1);
    chk(microstep_position_o, 8'h09, "pin step lost");
    $display("test wake and step done");
    uv_detect_i = 1'b1;
    tick(3);
    chk(undervoltage_flag_o, 1, "undervoltage flag");
    chk(fault_out_n_o, 0, "fault on undervoltage");
    uv_detect_i = 1'b0;
    en_write();
    chk(bridge_enable_o, 0, "enable under undervoltage");
    host.step_once(1'b0);
    chk(step_lost_flag_o, 1, "step loss not set");
    chk(microstep_position_o, 8'h08, "disabled positioner");
    rd_main_status_i = 1'b1;
    tick(1);
    rd_main_status_i = 1'b0;
    tick(1);
    chk(step_lost_flag_o, 0, "step loss kept after read");
    $display("test undervoltage done");
    en_write();
    overcurrent_detect_i = 8'h10;
    tick(1);
    overcurrent_detect_i = 8'h00;
    tick(2);
    chk(overcurrent_flags_o, 8'h10, "overcurrent bit");
    chk(electrical_fault_flag_o, 1, "fault flag");
    chk(bridge_enable_o, 0, "enable after short");
    rd_elec_status_i = 1'b1;
    tick(1);
    rd_elec_status_i = 1'b0;
    tick(1);
    chk(electrical_fault_flag_o, 0, "fault flag after read");
    $display("test overcurrent done");
    en_write();
    duty_full_i = 2'b01;
    repeat (9) begin
      pwm_period_start_i = 1'b1;
      tick(1);
      pwm_period_start_i = 1'b0;
      tick(1);
    end
    chk(coil_a_open_flag_o, 1, "coil a open not flagged");
    chk(coil_b_open_flag_o, 0, "coil b open flagged");
    chk(electrical_fault_flag_o, 1, "open fault");
    chk(bridge_enable_o, 1, "enable dropped on open");
    chk(bridge_a_drive_o, 0, "open coil still driven");
    chk(bridge_b_drive_o, 1, "sound coil stopped");
    duty_full_i = 2'b00;
    rd_elec_status_i = 1'b1;
    tick(1);
    rd_elec_status_i = 1'b0;
    $display("test open coil done");
    en_write();
    current_boost_bit_i = 1'b1;
    pwm_period_start_i = 1'b1;
    tick(1);
    pwm_period_start_i = 1'b0;
    tick(2);
    chk(boost_applied_o, 1, "boost not applied");
    tw_detect_i = 1'b1;
    tick(3);
    chk(thermal_warning_flag_o, 1, "warning flag");
    chk(fault_out_n_o, 0, "fault on warning");
    chk(bridge_enable_o, 1, "enable dropped on warning");
    chk(boost_applied_o, 0, "boost kept when warm");
    $display("test thermal warning done");
    host.pattern_reset();
    chk(reset_occurred_flag_o, 1, "pattern reset flag");
    chk(fault_out_n_o, 0, "fault high after pattern");
    chk(awake_o, 0, "awake after pattern");
    $display("test pattern reset done");
    conclude();
  end
endmodule
